// ==== rtl/cci_irq_pin.sv ====
/*
 * Interrupt pin sequencer: asserts the pin while an enabled source is pending
 * and handles a clear attempt made while something is still pending.
 * Assumes pending and clear_req come from logic on the same clock.
 */
`timescale 1ns/1ps
module cci_irq_pin #(
    parameter int unsigned GAP_CYCLES = cci_pkg::RETRY_GAP_CYCLES  // Retry release length.
) (
    input  wire logic clk_i,   // System clock.
    input  wire logic nrst_i,  // Asynchronous reset, active low.
    input  wire logic srst_i,  // Synchronous device reset.
    cci_irq_if.pin    irq      // Pending, clear and pin drive.
);

    typedef struct packed {
        cci_pkg::cci_pin_state_e                state;
        logic [cci_pkg::GAP_CNT_W-1:0]          gap_cnt;
    } cci_pin_s;

    localparam logic [cci_pkg::GAP_CNT_W-1:0] GAP_LAST = cci_pkg::GAP_CNT_W'(GAP_CYCLES - 1);

    cci_pin_s st_reg;
    cci_pin_s st_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            cci_pkg::PIN_IDLE: begin
                if (irq.pending) begin
                    st_next.state = cci_pkg::PIN_ASSERT;
                end
            end
            cci_pkg::PIN_ASSERT: begin
                if (!irq.pending) begin
                    st_next.state = cci_pkg::PIN_IDLE;
                end else if (irq.clear_req && irq.retry_mode) begin
                    st_next.state   = cci_pkg::PIN_GAP;
                    st_next.gap_cnt = '0;
                end
                // With retry mode off a clear leaves the pin asserted.
            end
            cci_pkg::PIN_GAP: begin
                if (st_reg.gap_cnt == GAP_LAST) begin
                    st_next.gap_cnt = '0;
                    st_next.state   = irq.pending ? cci_pkg::PIN_ASSERT : cci_pkg::PIN_IDLE;
                end else begin
                    st_next.gap_cnt = st_reg.gap_cnt + 1'b1;
                end
            end
            default: begin
                st_next.state   = cci_pkg::PIN_IDLE;
                st_next.gap_cnt = '0;
            end
        endcase
        if (srst_i) begin
            st_next.state   = cci_pkg::PIN_IDLE;
            st_next.gap_cnt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg.state   <= cci_pkg::PIN_IDLE;
            st_reg.gap_cnt <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign irq.pin_drive = (st_reg.state == cci_pkg::PIN_ASSERT);
    assign irq.in_gap    = (st_reg.state == cci_pkg::PIN_GAP);

endmodule

// ==== rtl/cci_top.sv ====
/*
 * Core configuration and interrupt-enable logic of a keypad and I/O expander.
 * Holds the global setup and interrupt enable registers, makes the 1 MHz
 * oscillator tick and the divided core clock tick, gates the reset pin and
 * drives the open-drain interrupt pin through the pin sequencer.
 * Assumes register accesses come from the serial interface engine on the same
 * clock, and that the source flags and clear attempts come from logic on the
 * same clock. The reset pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module cci_top #(
    parameter int unsigned RETRY_GAP_CYCLES = cci_pkg::RETRY_GAP_CYCLES  // Retry release length.
) (
    input  wire logic       clk_i,              // System clock, 100 MHz.
    input  wire logic       nrst_i,             // Asynchronous reset, active low.
    input  wire logic       rst_pin_n_i,        // External reset pin, active low.
    input  wire logic [7:0] reg_addr_i,         // Register address.
    input  wire logic       reg_wr_i,           // Write strobe.
    input  wire logic [7:0] reg_wdata_i,        // Write data.
    input  wire logic       reg_rd_i,           // Read strobe.
    output logic      [7:0] reg_rdata_o,        // Read data, one cycle after strobe.
    output logic            reg_rvalid_o,       // Read data valid pulse.
    input  wire logic       logic_irq_flag_i,   // Logic block interrupt flag.
    input  wire logic       overflow_irq_flag_i, // FIFO overflow flag.
    input  wire logic       input_change_flag_i, // General input change flag.
    input  wire logic       event_irq_flag_i,   // Key event flag.
    input  wire logic       irq_clear_i,        // Software clear attempt pulse.
    output logic            osc_tick_o,         // 1 MHz oscillator tick.
    output logic            core_tick_o,        // Core clock tick for scan timing.
    output logic            device_reset_o,     // Device reset from reset pin.
    output logic            irq_pending_o,      // Any enabled source pending.
    output logic            int_o,              // Interrupt pin output level.
    output logic            int_oe_n_o          // Interrupt pin enable, low drives.
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [1:0]                       rst_sync;
        logic                             dev_rst;
        logic [cci_pkg::OSC_CNT_W-1:0]    osc_cnt;
        logic                             osc_tick;
        logic [cci_pkg::CORE_CNT_W-1:0]   core_cnt;
        logic                             core_tick;
        logic [7:0]                       global_setup;
        logic [7:0]                       irq_enable_mask;
        logic [7:0]                       rdata;
        logic                             rvalid;
    } cci_core_s;

    cci_core_s st_reg;
    cci_core_s st_next;

    cci_irq_if irq_bus ();

    localparam logic [cci_pkg::OSC_CNT_W-1:0] OSC_LAST = cci_pkg::OSC_CNT_W'(cci_pkg::OSC_DIV - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding.

    // Last count of the core divider for a select code.
    function automatic logic [cci_pkg::CORE_CNT_W-1:0] core_last(input logic [1:0] sel);
        logic [cci_pkg::CORE_CNT_W-1:0] res;
        res = '0;
        case (sel)
            cci_pkg::CLK_SEL_50K:  res = cci_pkg::CORE_CNT_W'(cci_pkg::CORE_DIV_SEL0 - 1);
            cci_pkg::CLK_SEL_100K: res = cci_pkg::CORE_CNT_W'(cci_pkg::CORE_DIV_SEL1 - 1);
            cci_pkg::CLK_SEL_200K: res = cci_pkg::CORE_CNT_W'(cci_pkg::CORE_DIV_SEL2 - 1);
            cci_pkg::CLK_SEL_500K: res = cci_pkg::CORE_CNT_W'(cci_pkg::CORE_DIV_SEL3 - 1);
            default:               res = cci_pkg::CORE_CNT_W'(cci_pkg::CORE_DIV_SEL0 - 1);
        endcase
        return res;
    endfunction

    // Read value of a register address; unmapped addresses read zero.
    function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] gs, input logic [7:0] ie);
        logic [7:0] res;
        res = cci_pkg::UNMAPPED_READ;
        case (addr)
            cci_pkg::ADDR_GLOBAL_SETUP:    res = gs;
            cci_pkg::ADDR_IRQ_ENABLE_MASK: res = ie;
            default:                       res = cci_pkg::UNMAPPED_READ;
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Field views.

    logic       oscillator_on;
    logic [1:0] core_clock_select;
    logic       retry_mode;
    logic       rst_ignore;
    logic [3:0] src_flags;
    logic [3:0] src_enables;
    logic [3:0] src_active;

    assign oscillator_on     = st_reg.global_setup[cci_pkg::GS_OSC_ON_BIT];
    assign core_clock_select = st_reg.global_setup[cci_pkg::GS_CLK_SEL_HI:cci_pkg::GS_CLK_SEL_LO];
    assign retry_mode        = st_reg.global_setup[cci_pkg::GS_RETRY_BIT];
    assign rst_ignore        = st_reg.global_setup[cci_pkg::GS_RST_IGNORE_BIT];

    assign src_flags = {logic_irq_flag_i, overflow_irq_flag_i, input_change_flag_i, event_irq_flag_i};
    assign src_enables = {st_reg.irq_enable_mask[cci_pkg::IE_LOGIC_BIT],
                          st_reg.irq_enable_mask[cci_pkg::IE_OVERFLOW_BIT],
                          st_reg.irq_enable_mask[cci_pkg::IE_INPUT_BIT],
                          st_reg.irq_enable_mask[cci_pkg::IE_EVENT_BIT]};

    // Each source reaches the pin only through its own enable bit.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_src
            assign src_active[gi] = src_flags[gi] & src_enables[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        st_next = st_reg;

        // The first synchroniser stage feeds only the second.
        st_next.rst_sync = {st_reg.rst_sync[0], rst_pin_n_i};
        st_next.dev_rst  = !st_reg.rst_sync[1] && !rst_ignore;

        // Oscillator tick; the counter clears while the oscillator is off.
        st_next.osc_tick = 1'b0;
        if (oscillator_on) begin
            if (st_reg.osc_cnt >= OSC_LAST) begin
                st_next.osc_cnt  = '0;
                st_next.osc_tick = 1'b1;
            end else begin
                st_next.osc_cnt = st_reg.osc_cnt + 1'b1;
            end
        end else begin
            st_next.osc_cnt = '0;
        end

        // Core tick divided from the oscillator tick.
        st_next.core_tick = 1'b0;
        if (!oscillator_on) begin
            st_next.core_cnt = '0;
        end else if (st_reg.osc_tick) begin
            if (st_reg.core_cnt >= core_last(core_clock_select)) begin
                st_next.core_cnt  = '0;
                st_next.core_tick = 1'b1;
            end else begin
                st_next.core_cnt = st_reg.core_cnt + 1'b1;
            end
        end

        // Register writes; reserved bits stay zero.
        if (reg_wr_i) begin
            case (reg_addr_i)
                cci_pkg::ADDR_GLOBAL_SETUP: begin
                    st_next.global_setup = reg_wdata_i & cci_pkg::GS_WRITE_MASK;
                end
                cci_pkg::ADDR_IRQ_ENABLE_MASK: begin
                    st_next.irq_enable_mask = reg_wdata_i & cci_pkg::IE_WRITE_MASK;
                end
                default: begin
                    st_next.global_setup = st_reg.global_setup;
                end
            endcase
        end

        // Register reads answer one cycle after the strobe.
        st_next.rvalid = reg_rd_i;
        st_next.rdata  = reg_rd_i ? reg_read(reg_addr_i, st_reg.global_setup, st_reg.irq_enable_mask)
                                  : st_reg.rdata;

        // A device reset from the pin restores both registers and the dividers.
        if (st_reg.dev_rst) begin
            st_next.global_setup    = cci_pkg::RST_GLOBAL_SETUP;
            st_next.irq_enable_mask = cci_pkg::RST_IRQ_ENABLE_MASK;
            st_next.osc_cnt         = '0;
            st_next.osc_tick        = 1'b0;
            st_next.core_cnt        = '0;
            st_next.core_tick       = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg.rst_sync        <= 2'h3;
            st_reg.dev_rst         <= 1'b0;
            st_reg.osc_cnt         <= '0;
            st_reg.osc_tick        <= 1'b0;
            st_reg.core_cnt        <= '0;
            st_reg.core_tick       <= 1'b0;
            st_reg.global_setup    <= cci_pkg::RST_GLOBAL_SETUP;
            st_reg.irq_enable_mask <= cci_pkg::RST_IRQ_ENABLE_MASK;
            st_reg.rdata           <= 8'h00;
            st_reg.rvalid          <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin.

    assign irq_bus.pending    = |src_active;
    assign irq_bus.clear_req  = irq_clear_i;
    assign irq_bus.retry_mode = retry_mode;

    cci_irq_pin #(
        .GAP_CYCLES (RETRY_GAP_CYCLES)
    ) u_irq_pin (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .srst_i (st_reg.dev_rst),
        .irq    (irq_bus.pin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata_o    = st_reg.rdata;
    assign reg_rvalid_o   = st_reg.rvalid;
    assign osc_tick_o     = st_reg.osc_tick;
    assign core_tick_o    = st_reg.core_tick;
    assign device_reset_o = st_reg.dev_rst;
    assign irq_pending_o  = irq_bus.pending;
    assign int_o          = 1'b0;
    assign int_oe_n_o     = !irq_bus.pin_drive;

endmodule

// ==== shared/cci_irq_if.sv ====
/*
 * Carrier between the configuration core and the interrupt pin sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cci_irq_if;
    logic pending;     // Any enabled source flag set.
    logic clear_req;   // Software attempt to clear the pin.
    logic retry_mode;  // Release for the gap time when cleared while pending.
    logic pin_drive;   // Interrupt pin pulled low.
    logic in_gap;      // Pin released for the retry gap.

    modport core (
        output pending,
        output clear_req,
        output retry_mode,
        input  pin_drive,
        input  in_gap
    );

    modport pin (
        input  pending,
        input  clear_req,
        input  retry_mode,
        output pin_drive,
        output in_gap
    );
endinterface

// ==== shared/cci_pkg.sv ====
/*
 * Constants shared by the core configuration and interrupt-enable logic:
 * register offsets, field positions, reset values and timing counts.
 * Assumes the system clock runs at 100 MHz.
 */
package cci_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock rates and derived counts.
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned OSC_HZ          = 1_000_000;
    localparam int unsigned OSC_DIV         = CLK_HZ / OSC_HZ;
    localparam int unsigned CORE_HZ_SEL0    = 50_000;
    localparam int unsigned CORE_HZ_SEL1    = 100_000;
    localparam int unsigned CORE_HZ_SEL2    = 200_000;
    localparam int unsigned CORE_HZ_SEL3    = 500_000;
    localparam int unsigned CORE_DIV_SEL0   = OSC_HZ / CORE_HZ_SEL0;
    localparam int unsigned CORE_DIV_SEL1   = OSC_HZ / CORE_HZ_SEL1;
    localparam int unsigned CORE_DIV_SEL2   = OSC_HZ / CORE_HZ_SEL2;
    localparam int unsigned CORE_DIV_SEL3   = OSC_HZ / CORE_HZ_SEL3;
    localparam int unsigned OSC_CNT_W       = 7;
    localparam int unsigned CORE_CNT_W      = 5;

    // Release time of the interrupt pin in retry mode, in microseconds.
    localparam int unsigned RETRY_GAP_US     = 50;
    localparam int unsigned RETRY_GAP_CYCLES = (RETRY_GAP_US * (CLK_HZ / 1_000_000));
    localparam int unsigned GAP_CNT_W        = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [7:0] ADDR_GLOBAL_SETUP    = 8'h3B;
    localparam logic [7:0] ADDR_IRQ_ENABLE_MASK = 8'h3C;
    localparam logic [7:0] RST_GLOBAL_SETUP     = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLE_MASK  = 8'h00;
    localparam logic [7:0] UNMAPPED_READ        = 8'h00;

    // Field positions of global_setup.
    localparam int unsigned GS_OSC_ON_BIT     = 7;
    localparam int unsigned GS_CLK_SEL_HI     = 6;
    localparam int unsigned GS_CLK_SEL_LO     = 5;
    localparam int unsigned GS_RETRY_BIT      = 1;
    localparam int unsigned GS_RST_IGNORE_BIT = 0;
    localparam logic [7:0]  GS_WRITE_MASK     = 8'hE3;

    // Field positions of irq_enable_mask.
    localparam int unsigned IE_LOGIC_BIT    = 4;
    localparam int unsigned IE_OVERFLOW_BIT = 2;
    localparam int unsigned IE_INPUT_BIT    = 1;
    localparam int unsigned IE_EVENT_BIT    = 0;
    localparam logic [7:0]  IE_WRITE_MASK   = 8'h17;

    // Core clock select codes.
    localparam logic [1:0] CLK_SEL_50K  = 2'h0;
    localparam logic [1:0] CLK_SEL_100K = 2'h1;
    localparam logic [1:0] CLK_SEL_200K = 2'h2;
    localparam logic [1:0] CLK_SEL_500K = 2'h3;

    // Interrupt pin states.
    typedef enum logic [2:0] {
        PIN_IDLE   = 3'h1,
        PIN_ASSERT = 3'h2,
        PIN_GAP    = 3'h4
    } cci_pin_state_e;

endpackage

// ==== tb/cci_host_model.sv ====
/* Host model: register strobe master and the pulled-up interrupt line.
   Assumes strobes are taken at the rising clock edge. */
`timescale 1ns/1ps
module cci_host_model (
    input  wire logic       clk_i,      // Clock.
    output logic      [7:0] addr_o,     // Address.
    output logic            wr_o,       // Write.
    output logic      [7:0] wdata_o,    // Write data.
    output logic            rd_o,       // Read.
    input  wire logic [7:0] rdata_i,    // Read data.
    input  wire logic       rvalid_i,   // Read valid.
    input  wire logic       int_i,      // Pin value.
    input  wire logic       int_oe_n_i, // Pin enable.
    output logic            int_line_o  // Line level.
);
    // The line has a pull-up, so it reads high whenever the pin is released.
    assign int_line_o = int_oe_n_i ? 1'b1 : int_i;
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = rdata_i;
        v = rvalid_i;
    endtask
endmodule

// ==== tb/cci_top_bench.sv ====
/* Self-checking bench of the configuration and interrupt-enable block.
   Assumes the host model drives the register port. */
`timescale 1ns/1ps
module cci_top_bench;
    localparam int unsigned GAP = 20;
    logic       clk_i, nrst_i, rst_pin_n_i, wr, rd, rvalid, clr, ot, ct, dres, pend, io, ioe, line;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] flags;
    int         err_total, check_count, cyc;
    cci_top #(.RETRY_GAP_CYCLES(GAP)) i_cci_top (
        .clk_i(clk_i), .nrst_i(nrst_i), .rst_pin_n_i(rst_pin_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .logic_irq_flag_i(flags[3]), .overflow_irq_flag_i(flags[2]), .input_change_flag_i(flags[1]),
        .event_irq_flag_i(flags[0]), .irq_clear_i(clr), .osc_tick_o(ot), .core_tick_o(ct),
        .device_reset_o(dres), .irq_pending_o(pend), .int_o(io), .int_oe_n_o(ioe)
    );
    cci_host_model i_cci_host_model (
        .clk_i(clk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata),
        .rvalid_i(rvalid), .int_i(io), .int_oe_n_i(ioe), .int_line_o(line)
    );
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        i_cci_host_model.rd(a, d, v);
        cmp("rvalid", 16'h0001, 16'(v));
        cmp(n, 16'(e), 16'(d));
    endtask
    task automatic t_regs;
        rd_chk("setup reset", cci_pkg::ADDR_GLOBAL_SETUP, cci_pkg::RST_GLOBAL_SETUP);
        rd_chk("mask reset", cci_pkg::ADDR_IRQ_ENABLE_MASK, cci_pkg::RST_IRQ_ENABLE_MASK);
        i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, 8'hFF);
        i_cci_host_model.wr(cci_pkg::ADDR_IRQ_ENABLE_MASK, 8'hFF);
        rd_chk("setup bits", cci_pkg::ADDR_GLOBAL_SETUP, cci_pkg::GS_WRITE_MASK);
        rd_chk("mask bits", cci_pkg::ADDR_IRQ_ENABLE_MASK, cci_pkg::IE_WRITE_MASK);
        rd_chk("unmapped", 8'h3D, cci_pkg::UNMAPPED_READ);
        i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, 8'h00);
    endtask
    task automatic t_masks;
        int unsigned pos[4] = '{cci_pkg::IE_EVENT_BIT, cci_pkg::IE_INPUT_BIT,
                                cci_pkg::IE_OVERFLOW_BIT, cci_pkg::IE_LOGIC_BIT};
        for (int i = 0; i < 4; i++) begin
            i_cci_host_model.wr(cci_pkg::ADDR_IRQ_ENABLE_MASK, 8'h01 << pos[i]);
            for (int j = 0; j < 4; j++) begin
                flags = 4'h1 << j;
                repeat (2) @(negedge clk_i);
                cmp("pending", 16'(i == j), 16'(pend));
                cmp("int line", 16'(i != j), 16'(line));
                flags = 4'h0;
                @(negedge clk_i);
            end
        end
    endtask
    task automatic t_retry(input logic mode);
        int n;
        i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, {6'h00, mode, 1'b0});
        i_cci_host_model.wr(cci_pkg::ADDR_IRQ_ENABLE_MASK, 8'h01);
        flags = 4'h1;
        repeat (3) @(negedge clk_i);
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        n = 0;
        while (line !== 1'b0 && n < 100) begin
            n++;
            @(negedge clk_i);
        end
        cmp("release cycles", mode ? 16'(GAP) : 16'h0000, 16'(n));
        flags = 4'h0;
        i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, 8'h00);
    endtask
    task automatic t_rstpin;
        i_cci_host_model.wr(cci_pkg::ADDR_IRQ_ENABLE_MASK, 8'h17);
        rst_pin_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        cmp("device reset", 16'h0001, 16'(dres));
        rst_pin_n_i = 1'b1;
        repeat (6) @(negedge clk_i);
        cmp("device reset off", 16'h0000, 16'(dres));
        rd_chk("mask cleared", cci_pkg::ADDR_IRQ_ENABLE_MASK, 8'h00);
        i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, 8'h01);
        rst_pin_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        cmp("reset ignored", 16'h0000, 16'(dres));
        rd_chk("setup kept", cci_pkg::ADDR_GLOBAL_SETUP, 8'h01);
        rst_pin_n_i = 1'b1;
        i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, 8'h00);
    endtask
    task automatic tick_gap(input bit core, output int n);
        int k;
        k = 0;
        while ((core ? ct : ot) !== 1'b1 && k < 5000) begin
            k++;
            @(negedge clk_i);
        end
        n = 0;
        do begin
            n++;
            @(negedge clk_i);
        end while ((core ? ct : ot) !== 1'b1 && n < 5000);
    endtask
    task automatic t_clock;
        int unsigned dv[4] = '{cci_pkg::CORE_DIV_SEL0, cci_pkg::CORE_DIV_SEL1,
                               cci_pkg::CORE_DIV_SEL2, cci_pkg::CORE_DIV_SEL3};
        int n;
        for (int s = 0; s < 4; s++) begin
            i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, 8'h80 | 8'(s << 5));
            tick_gap(1'b0, n);
            cmp("osc period", 16'(cci_pkg::OSC_DIV), 16'(n));
            tick_gap(1'b1, n);
            cmp("core period", 16'(dv[s] * cci_pkg::OSC_DIV), 16'(n));
            i_cci_host_model.wr(cci_pkg::ADDR_GLOBAL_SETUP, 8'h00);
            repeat (120) @(negedge clk_i);
        end
        n = 0;
        repeat (300) begin
            @(negedge clk_i);
            n += int'(ot === 1'b1);
        end
        cmp("ticks when off", 16'h0000, 16'(n));
    endtask
    initial begin
        nrst_i = 1'b0;
        rst_pin_n_i = 1'b1;
        flags = 4'h0;
        clr = 1'b0;
        err_total = 0;
        check_count = 0;
        repeat (20) @(negedge clk_i);
        nrst_i = 1'b1;
        t_regs();
        t_masks();
        t_retry(1'b0);
        t_retry(1'b1);
        t_rstpin();
        t_clock();
        test_done();
    end
endmodule

// ==== tb/cci_top_sva.sv ====
/* Checker of the configuration registers, clock ticks, reset gating and interrupt pin.
   Assumes one clock and sees only the ports of the top module. */
`timescale 1ns/1ps
module cci_top_sva #(
    parameter int GAP = 20  // Retry release cycles.
) (
    input wire logic       clk_i,          // Clock.
    input wire logic       nrst_i,         // Reset.
    input wire logic       rst_pin_n_i,    // Reset pin.
    input wire logic [7:0] reg_addr_i,     // Address.
    input wire logic       reg_wr_i,       // Write.
    input wire logic [7:0] reg_wdata_i,    // Write data.
    input wire logic [7:0] reg_rdata_o,    // Read data.
    input wire logic       reg_rvalid_o,   // Read valid.
    input wire logic       irq_clear_i,    // Clear.
    input wire logic       osc_tick_o,     // Osc tick.
    input wire logic       core_tick_o,    // Core tick.
    input wire logic       device_reset_o, // Reset out.
    input wire logic       irq_pending_o,  // Pending.
    input wire logic       int_oe_n_o      // Pin enable.
);
    localparam int GAP_D = GAP;
    localparam int OSC_D = cci_pkg::OSC_DIV;
    localparam int DV[4] = '{cci_pkg::CORE_DIV_SEL0, cci_pkg::CORE_DIV_SEL1,
                             cci_pkg::CORE_DIV_SEL2, cci_pkg::CORE_DIV_SEL3};
    logic        osc_q, retry_q, ign_q, dirty_q, gs_wr;
    logic [1:0]  sel_q;
    logic [7:0]  oc_q;
    logic [15:0] nclr_q;
    assign gs_wr = reg_wr_i && reg_addr_i == cci_pkg::ADDR_GLOBAL_SETUP;
    // Mirror of the setup fields; a count is judged only once the select is settled.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {osc_q, sel_q, retry_q, ign_q} <= 5'h00;
            dirty_q <= 1'b1;
            oc_q <= 8'h00;
            nclr_q <= 16'hFFFF;
        end else begin
            if (device_reset_o) begin
                {osc_q, sel_q, retry_q, ign_q} <= 5'h00;
            end else if (gs_wr) begin
                {osc_q, sel_q, retry_q, ign_q} <= {reg_wdata_i[7:5], reg_wdata_i[1:0]};
            end
            dirty_q <= gs_wr || device_reset_o || (dirty_q && !core_tick_o);
            oc_q <= core_tick_o ? 8'h00 : oc_q + 8'(osc_tick_o);
            nclr_q <= irq_clear_i ? 16'h0000 : nclr_q + 16'(nclr_q != 16'hFFFF);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////
    chk_gs_reserved: assert property (
        reg_rvalid_o && $past(reg_addr_i) == cci_pkg::ADDR_GLOBAL_SETUP
        |-> (reg_rdata_o & ~cci_pkg::GS_WRITE_MASK) == 8'h00) else $error("setup reserved bits set");
    chk_ie_reserved: assert property (
        reg_rvalid_o && $past(reg_addr_i) == cci_pkg::ADDR_IRQ_ENABLE_MASK
        |-> (reg_rdata_o & ~cci_pkg::IE_WRITE_MASK) == 8'h00) else $error("mask reserved bits set");
    chk_osc_off: assert property (!osc_q |=> !osc_tick_o) else $error("tick with oscillator off");
    chk_osc_period: assert property (
        osc_tick_o && osc_q |-> ##OSC_D (osc_tick_o || !osc_q)) else $error("oscillator period wrong");
    chk_core_div: assert property (
        core_tick_o && !dirty_q |-> oc_q == DV[sel_q]) else $error("core divide wrong");
    chk_idle_release: assert property (
        !irq_pending_o |=> int_oe_n_o) else $error("pin driven without pending");
    chk_pend_drives: assert property (
        irq_pending_o && nclr_q > GAP + 2 |=> !int_oe_n_o) else $error("pending not on pin");
    chk_no_retry: assert property (
        irq_clear_i && irq_pending_o && !int_oe_n_o && !retry_q |=> !int_oe_n_o)
        else $error("pin released in hold mode");
    chk_gap_hold: assert property (
        irq_clear_i && irq_pending_o && !int_oe_n_o && retry_q |=> int_oe_n_o [*8])
        else $error("retry release too short");
    chk_gap_end: assert property (
        irq_clear_i && irq_pending_o && !int_oe_n_o && retry_q
        |=> ##GAP_D (!int_oe_n_o || !$past(irq_pending_o))) else $error("no reassert after gap");
    chk_rst_taken: assert property (
        $fell(rst_pin_n_i) && !ign_q |-> ##[1:4] device_reset_o) else $error("reset pin not honoured");
    chk_rst_ignored: assert property (
        !rst_pin_n_i && ign_q |-> !device_reset_o) else $error("reset pin not ignored");
endmodule

bind cci_top cci_top_sva #(.GAP(RETRY_GAP_CYCLES)) i_cci_top_sva (
    .clk_i(clk_i), .nrst_i(nrst_i), .rst_pin_n_i(rst_pin_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .irq_clear_i(irq_clear_i), .osc_tick_o(osc_tick_o),
    .core_tick_o(core_tick_o), .device_reset_o(device_reset_o), .irq_pending_o(irq_pending_o),
    .int_oe_n_o(int_oe_n_o)
);
